/* File: design/adc_group_scheduler.sv */
// conversion group scheduler: entry/execution flags, selection, channel walk
// assumes triggers are synchronous pulses and the sar core timing is counted here
`timescale 1ns/1ps
module adc_group_scheduler
  import adc_sched_pkg::*;
#(
  parameter int NG = NUM_GROUPS,
  parameter int NC = NUM_CHANS
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // configuration
  input  adc_sched_pkg::group_cfg_t      group_cfg [NG],
  input  wire logic [SMP_W-1:0]          sample_cycles,
  input  wire logic [NG-1:0]             cpu_loop_trigger_reg,
  input  wire logic [NG-1:0]             cpu_oneshot_trigger,
  input  wire logic [NG-1:0]             group_done_clear,
  // peripheral trigger sources
  input  wire logic [NUM_SRCS-1:0]       src_events,
  // status
  output logic [NG-1:0]                  group_exec_status_reg,
  output logic [NG-1:0]                  group_entry_status_reg,
  output logic [NG-1:0]                  group_done_flag_reg,
  output adc_sched_pkg::group_state_t    group_state_r [NG],
  // converter core side
  output logic                           sample_en_r,
  output logic [3:0]                     conv_chan_r,
  output logic                           chan_done_r,
  output logic [NG-1:0]                  group_event_r
);
  import adc_sched_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SELECT,
    ST_SAMPLE,
    ST_CONVERT
  } seq_state_t;

  logic                rst_meta_b, rst_sync_b;
  seq_state_t          state_r;
  logic [2:0]          grp_r;
  logic [MASK_W-1:0]   left_r;
  logic [8:0]          cnt_r;
  logic                first_r;
  logic [NG-1:0]       ev_trig, trig_any, loop_q_r;
  logic [MASK_W-1:0]   mask_now, emask_now, next_mask;
  logic                grp_any;
  logic [2:0]          grp_idx;
  logic                ch_any;
  logic [3:0]          ch_idx, conv_run_r;
  logic [MASK_W-1:0]   ch_bit;
  logic                last_ch, next_one, clr_last, clr_single;
  logic [NG-1:0]       done_set, exec_clr_entry;
  logic [8:0]          smp_len;
  default clocking cb_sched @(posedge sys_clk);
  endclocking
  default disable iff (!rst_sync_b);

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end
    else
    begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // loop request registered: it fires one cycle behind the one-shot
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      loop_q_r <= GROUP_RST;
    else
      loop_q_r <= cpu_loop_trigger_reg;
  end

  genvar g;
  generate
    for (g = 0; g < NG; g++)
    begin : g_trig
      trig_select u_sel (
        .src_events (src_events),
        .sel        (group_cfg[g].trigger_source_select),
        .trig       (ev_trig[g])
      );
    end
  endgenerate

  assign trig_any = ev_trig | cpu_oneshot_trigger | loop_q_r;

  // mask only channels 0..11 may be used
  localparam logic [MASK_W-1:0] CH_VALID = MASK_W'((1 << NC) - 1);
  assign mask_now  = {group_cfg[grp_r].chan_mask_high,
                      group_cfg[grp_r].chan_mask_low} & CH_VALID;
  assign emask_now = {group_cfg[grp_r].event_mask_high,
                      group_cfg[grp_r].event_mask_low};
  assign next_mask = {group_cfg[grp_idx].chan_mask_high,
                      group_cfg[grp_idx].chan_mask_low} & CH_VALID;

  lowest_pick #(.W(NG), .IW(3)) u_grp (
    .req (group_entry_status_reg),
    .any (grp_any),
    .idx (grp_idx)
  );

  lowest_pick #(.W(MASK_W), .IW(4)) u_ch (
    .req (left_r),
    .any (ch_any),
    .idx (ch_idx)
  );

  assign ch_bit  = MASK_W'(1) << ch_idx;
  assign last_ch = ((left_r & ~ch_bit) == '0);
  assign smp_len = (sample_cycles == '0) ? 9'd256 : {1'b0, sample_cycles};

  // entry drops when the last channel starts sampling; with one channel (or none)
  // it drops on the edge that raises the execution bit, so no stale entry reruns it
  assign clr_last       = state_r == ST_SAMPLE && cnt_r == '0 && last_ch && left_r != mask_now;
  assign next_one       = (next_mask & (next_mask - MASK_W'(1))) == '0;
  assign clr_single     = next_one && grp_any && (state_r == ST_SELECT || |done_set);
  assign exec_clr_entry = (clr_last ? NG'(1) << grp_r : NG'(0))
                          | (clr_single ? NG'(1) << grp_idx : NG'(0));

  // done when final channel conversion ends
  assign done_set = (state_r == ST_CONVERT && cnt_r == 9'(SAR_CYCLES - 1) && last_ch)
                    ? NG'(1) << grp_r : NG'(0);

  // entry flags
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      group_entry_status_reg <= GROUP_RST;
    else
      // set already entered is a no-op, so repeats never accumulate
      group_entry_status_reg <= (group_entry_status_reg & ~exec_clr_entry)
                                | trig_any;
  end

  // completion flags, hardware set wins over clear
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      group_done_flag_reg <= GROUP_RST;
    else
      group_done_flag_reg <= (group_done_flag_reg & ~group_done_clear)
                             | done_set;
  end

  // sequencer
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state_r               <= ST_IDLE;
      grp_r                 <= '0;
      left_r                <= MASK_RST;
      cnt_r                 <= '0;
      first_r               <= 1'b0;
      group_exec_status_reg <= GROUP_RST;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (grp_any)
          begin
            state_r <= ST_SELECT;
            first_r <= 1'b1;
          end
        end
        ST_SELECT:
        begin
          // pick taken only when idle or after completion
          grp_r                 <= grp_idx;
          group_exec_status_reg <= GROUP_RST;
          group_exec_status_reg[grp_idx] <= 1'b1;
          left_r  <= next_mask;
          cnt_r   <= '0;
          state_r <= grp_any ? ST_SAMPLE : ST_IDLE;
        end
        ST_SAMPLE:
        begin
          if (!ch_any)
          begin
            // empty mask: finish at once
            group_exec_status_reg <= GROUP_RST;
            state_r <= ST_IDLE;
          end
          else if (cnt_r == 9'(smp_len - 9'(1) + 9'(first_r ? START_EXTRA : 0)))
          begin
            cnt_r   <= '0;
            first_r <= 1'b0;
            state_r <= ST_CONVERT;
          end
          else
            cnt_r <= cnt_r + 9'd1;
        end
        ST_CONVERT:
        begin
          if (cnt_r == 9'(SAR_CYCLES - 1))
          begin
            cnt_r  <= '0;
            left_r <= left_r & ~ch_bit;
            if (last_ch)
            begin
              group_exec_status_reg <= GROUP_RST;
              // back-to-back group keeps the shorter timing
              if (grp_any)
              begin
                grp_r  <= grp_idx;
                group_exec_status_reg[grp_idx] <= 1'b1;
                left_r <= next_mask;
                state_r <= ST_SAMPLE;
              end
              else
                state_r <= ST_IDLE;
            end
            else
              state_r <= ST_SAMPLE;
          end
          else
            cnt_r <= cnt_r + 9'd1;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // core side outputs and events
  always_ff @(posedge sys_clk or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      sample_en_r   <= 1'b0;
      conv_chan_r   <= '0;
      chan_done_r   <= 1'b0;
      group_event_r <= GROUP_RST;
    end
    else
    begin
      sample_en_r   <= (state_r == ST_SAMPLE) && ch_any;
      conv_chan_r   <= ch_idx;
      chan_done_r   <= (state_r == ST_CONVERT) && (cnt_r == 9'(SAR_CYCLES - 1));
      group_event_r <= '0;
      if (state_r == ST_CONVERT && cnt_r == 9'(SAR_CYCLES - 1) && emask_now[ch_idx])
        group_event_r[grp_r] <= 1'b1;
    end
  end

  // state decode per group
  generate
    for (g = 0; g < NG; g++)
    begin : g_state
      always_ff @(posedge sys_clk or negedge rst_sync_b)
      begin
        if (!rst_sync_b)
          group_state_r[g] <= GS_STOPPED;
        else
          group_state_r[g] <= group_state_t'({group_exec_status_reg[g],
                                              group_entry_status_reg[g]});
      end
    end
  endgenerate

  // helper for the sar length check: a counter, since long repeats bloat the checker
  always_ff @(posedge sys_clk)
    conv_run_r <= (state_r == ST_CONVERT) ? conv_run_r + 4'd1 : 4'd0;
  property p_done_set;
    |done_set |=> |(group_done_flag_reg & $past(done_set));
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");
  property p_one_exec;
    $onehot0(group_exec_status_reg);
  endproperty
  a_one_exec: assert property (p_one_exec) else $error("two groups executing");
  property p_trig_enter;
    cpu_oneshot_trigger[0] |=> group_entry_status_reg[0];
  endproperty
  a_trig_enter: assert property (p_trig_enter) else $error("trigger not entered");
  property p_loop;
    !($past(rst_sync_b) && $past(rst_sync_b, 2))
      || ($past(cpu_loop_trigger_reg, 2) & ~group_entry_status_reg) == '0;
  endproperty
  a_loop: assert property (p_loop) else $error("loop did not enter");
  property p_event_chan;
    |group_event_r |-> chan_done_r;
  endproperty
  a_event_chan: assert property (p_event_chan) else $error("event without channel");
  property p_chan_range;
    sample_en_r |-> conv_chan_r < 4'(NC);
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel out of range");
  property p_conv_len;
    state_r == ST_CONVERT
      |=> (state_r == ST_CONVERT) == ($past(conv_run_r) != 4'(SAR_CYCLES - 1));
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("sar length wrong");
  property p_clear_last;
    |exec_clr_entry && !(|trig_any) |=> !(|(group_entry_status_reg & $past(exec_clr_entry)));
  endproperty
  a_clear_last: assert property (p_clear_last) else $error("entry not cleared");
  c_done: cover property (|done_set);
  c_event: cover property (|group_event_r);
  c_b2b: cover property (|done_set && grp_any);
endmodule : adc_group_scheduler

/* File: inc/adc_sched_pkg.sv */
// package: constants and carriers for the conversion group scheduler
// assumes one 100 MHz clock and plain-port configuration from the cpu side
package adc_sched_pkg;
  localparam int NUM_GROUPS    = 8;
  localparam int NUM_CHANS     = 12;
  localparam int MASK_W        = 16;
  localparam int SRC_W         = 6;
  localparam int NUM_SRCS      = 58;
  localparam int SAR_CYCLES    = 12;
  localparam int START_EXTRA   = 1;
  localparam int SMP_W         = 8;
  localparam logic [SRC_W-1:0] SRC_NONE      = 6'h00;
  localparam logic [SRC_W-1:0] SRC_GPIO_LO   = 6'h01;
  localparam logic [SRC_W-1:0] SRC_GPIO_HI   = 6'h09;
  localparam logic [SRC_W-1:0] SRC_CMP_LO    = 6'h0A;
  localparam logic [SRC_W-1:0] SRC_CMP_HI    = 6'h0F;
  localparam logic [SRC_W-1:0] SRC_TMR_LO    = 6'h12;
  localparam logic [SRC_W-1:0] SRC_TMR_HI    = 6'h19;
  localparam logic [SRC_W-1:0] SRC_PWM_LO    = 6'h1A;
  localparam logic [SRC_W-1:0] SRC_PWM_HI    = 6'h21;
  localparam logic [SRC_W-1:0] SRC_EVP_LO    = 6'h22;
  localparam logic [SRC_W-1:0] SRC_EVP_HI    = 6'h39;
  localparam logic [7:0]       GROUP_RST     = 8'h00;
  localparam logic [MASK_W-1:0] MASK_RST     = 16'h0000;

  typedef struct packed {
    logic [7:0] chan_mask_low;
    logic [7:0] chan_mask_high;
    logic [7:0] event_mask_low;
    logic [7:0] event_mask_high;
    logic [SRC_W-1:0] trigger_source_select;
  } group_cfg_t;

  typedef enum logic [1:0] {
    GS_STOPPED,
    GS_IDLING,
    GS_FINAL,
    GS_BUSY
  } group_state_t;
endpackage : adc_sched_pkg

/* File: design/lowest_pick.sv */
// lowest set bit picker with any and index outputs
// assumes combinational use inside the scheduler
`timescale 1ns/1ps
module lowest_pick #(
  parameter int W  = 16,
  parameter int IW = 4
) (
  // request vector
  input  wire logic [W-1:0]  req,
  // result
  output logic               any,
  output logic [IW-1:0]      idx
);
  always_comb
  begin
    any = 1'b0;
    idx = '0;
    for (int i = W - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        any = 1'b1;
        idx = IW'(i);
      end
    end
  end
endmodule : lowest_pick

/* File: design/trig_select.sv */
// per-group trigger source multiplexer
// assumes peripheral events are one-cycle pulses synchronous to sys_clk
`timescale 1ns/1ps
module trig_select
  import adc_sched_pkg::*;
#(
  parameter int NS = NUM_SRCS
) (
  // source vector, bit 0 unused
  input  wire logic [NS-1:0]    src_events,
  input  wire logic [SRC_W-1:0] sel,
  // selected trigger
  output logic                  trig
);
  always_comb
  begin
    // source zero means no event trigger
    if (sel == SRC_NONE || int'(sel) >= NS)
      trig = 1'b0;
    else
      trig = src_events[sel];
  end
endmodule : trig_select

/* File: sim/trig_src_model.sv */
// trigger source model: one-cycle peripheral event pulses picked by source number
// assumes the bench raises fire for one cycle per source number just after a rising edge
`timescale 1ns/1ps
module trig_src_model
(
  // clock
  input  wire logic                              sys_clk,
  // request from the bench
  input  wire logic                              fire,
  input  wire logic [adc_sched_pkg::SRC_W-1:0]   src_num,
  // event lines, index is the source number
  output logic [adc_sched_pkg::NUM_SRCS-1:0]     src_events
);
  import adc_sched_pkg::*;
  // event clock and routing taken as already prepared by software
  always @(posedge sys_clk)
  begin
    src_events <= '0;
    // source 0 and numbers past the table never pulse
    if (fire && src_num != SRC_NONE && src_num <= SRC_EVP_HI)
      src_events[src_num] <= 1'b1;
  end
endmodule : trig_src_model

/* File: sim/adc_group_scheduler_tb.sv */
// bench for the conversion group scheduler: table rows first, then hand cases
// assumes the package and the trigger source model are compiled before it
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
module adc_group_scheduler_tb;
  import adc_sched_pkg::*;
  localparam int SMP = 3;
  typedef struct {int g; logic [15:0] cm; logic [15:0] em; logic [SRC_W-1:0] src;} row_t;
  logic                sys_clk, rst_b, fire, smp_en, cdone, smp_q;
  group_cfg_t          cfg [NUM_GROUPS];
  group_state_t        gst [NUM_GROUPS];
  logic [SMP_W-1:0]    smp_len;
  logic [7:0]          loop_b, shot, clr, exec_s, entry_s, done_s, gevt, exec_q;
  logic [SRC_W-1:0]    src_num;
  logic [NUM_SRCS-1:0] src_ev;
  logic [3:0]          chan;
  logic [3:0]          chq [$];
  logic [7:0]          exq [$];
  int                  gaps [$];
  int                  num_errors = 0, checks_done = 0, cyc = 0, last_done = 0, evt_cnt = 0;
  row_t rows [7] = '{'{0, 16'h0001, 16'h0001, SRC_NONE}, '{1, 16'hF822, 16'h0802, 6'h01},
    '{2, 16'h0300, 16'h0300, 6'h0A}, '{3, 16'h0810, 16'h0000, 6'h12},
    '{4, 16'h0005, 16'h0004, 6'h1A}, '{5, 16'h0840, 16'h0840, 6'h22},
    '{7, 16'h0003, 16'h0002, 6'h39}};
  logic [7:0] ord [4] = '{8'h40, 8'h02, 8'h20, 8'h40};

  trig_src_model src_u (.sys_clk(sys_clk), .fire(fire), .src_num(src_num), .src_events(src_ev));
  adc_group_scheduler dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .group_cfg(cfg),
    .sample_cycles(smp_len), .cpu_loop_trigger_reg(loop_b), .cpu_oneshot_trigger(shot),
    .group_done_clear(clr), .src_events(src_ev), .group_exec_status_reg(exec_s),
    .group_entry_status_reg(entry_s), .group_done_flag_reg(done_s), .group_state_r(gst),
    .sample_en_r(smp_en), .conv_chan_r(chan), .chan_done_r(cdone), .group_event_r(gevt));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // channel starts, spacing of finished channels, event pulses, executing groups
  always @(posedge sys_clk)
  begin
    cyc++;
    if (smp_en === 1'b1 && smp_q !== 1'b1) chq.push_back(chan);
    smp_q = smp_en;
    if (cdone === 1'b1) gaps.push_back(cyc - last_done);
    if (cdone === 1'b1) last_done = cyc;
    evt_cnt += $countones(gevt);
    if (exec_s !== exec_q && exec_s !== 8'h00) exq.push_back(exec_s);
    exec_q = exec_s;
  end

  task automatic tick(input int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // bounded wait, a hang here counts as a mismatch
  task automatic wait_idle();
    int k;
    k = 0;
    while (!(exec_s === 8'h00 && entry_s === 8'h00) && k < 3000) begin tick(); k++; end
    `CHK("idle", 1'b1, k < 3000)
    tick(2);
  endtask : wait_idle

  task automatic run_row(input row_t r);
    logic [15:0] m;
    int n, k;
    m = r.cm & 16'h0FFF;
    cfg[r.g] = '{r.cm[7:0], r.cm[15:8], r.em[7:0], r.em[15:8], r.src};
    chq.delete();
    gaps.delete();
    evt_cnt = 0;
    tick();
    if (r.src == SRC_NONE) shot[r.g] = 1'b1;
    else fire = 1'b1;
    src_num = r.src;
    tick();
    shot = '0;
    fire = 1'b0;
    k = 0;
    while (exec_s[r.g] !== 1'b1 && k < 20) begin tick(); k++; end
    `CHK("entry_at_exec", $countones(m) > 1, entry_s[r.g])
    wait_idle();
    n = 0;
    for (int c = 0; c < NUM_CHANS; c++)
      if (m[c]) begin `CHK("chan", c[3:0], chq[n]) n++; end
    `CHK("chan_count", n, chq.size())
    `CHK("events", $countones(m & r.em), evt_cnt)
    `CHK("done", 1'b1, done_s[r.g])
    for (int i = 1; i < gaps.size(); i++) `CHK("gap", SMP + 12, gaps[i])
    clr[r.g] = 1'b1;
    tick();
    clr = '0;
    tick();
    `CHK("done_clr", 1'b0, done_s[r.g])
    `CHK("state", GS_STOPPED, gst[r.g])
    $display("test row group %0d done", r.g);
  endtask : run_row

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    num_errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    end_of_test();
  end

  initial
  begin
    int k;
    rst_b = 1'b0;
    fire = 1'b0;
    src_num = SRC_NONE;
    smp_len = SMP;
    loop_b = '0;
    shot = '0;
    clr = '0;
    foreach (cfg[i]) cfg[i] = '0;
    repeat (4) @(posedge sys_clk);
    `CHK("rst_exec", 8'h00, exec_s)
    `CHK("rst_entry", 8'h00, entry_s)
    `CHK("rst_done", 8'h00, done_s)
    #1 rst_b = 1'b1;
    tick(3);
    $display("test reset done");
    foreach (rows[i]) run_row(rows[i]);
    // lowest entered group wins, no preemption, repeats dropped
    cfg[6] = '{8'h03, 8'h00, 8'h00, 8'h00, SRC_NONE};
    exq.delete();
    shot[6] = 1'b1;
    tick();
    shot = '0;
    k = 0;
    while (exec_s !== 8'h40 && k < 20) begin tick(); k++; end
    tick();
    `CHK("entry_busy", 1'b1, entry_s[6])
    `CHK("state_busy", GS_BUSY, gst[6])
    shot[5] = 1'b1;
    tick(2);
    shot = 8'h22;
    tick();
    shot = '0;
    tick(2);
    `CHK("no_preempt", 8'h40, exec_s)
    `CHK("entered", 8'h62, entry_s)
    `CHK("state_idle", GS_IDLING, gst[5])
    k = 0;
    while (!(chan === 4'h1 && exec_s === 8'h40) && k < 100) begin tick(); k++; end
    tick(2);
    `CHK("entry_final", 1'b0, entry_s[6])
    `CHK("state_final", GS_FINAL, gst[6])
    shot[6] = 1'b1;
    tick();
    shot = '0;
    tick();
    `CHK("reentry_final", 1'b1, entry_s[6])
    wait_idle();
    `CHK("order_len", 4, exq.size())
    foreach (ord[i]) `CHK("order", ord[i], exq[i])
    $display("test priority done");
    // one source shared by two groups; source zero selects nothing
    cfg[4].trigger_source_select = 6'h12;
    cfg[2].trigger_source_select = SRC_NONE;
    exq.delete();
    fire = 1'b1;
    src_num = 6'h12;
    tick();
    src_num = 6'h0A;
    tick();
    fire = 1'b0;
    tick(3);
    `CHK("src_zero", 1'b0, entry_s[2])
    wait_idle();
    `CHK("shared_len", 2, exq.size())
    `CHK("shared_first", 8'h08, exq[0])
    `CHK("shared_next", 8'h10, exq[1])
    $display("test sources done");
    // loop request keeps group 3 re-entered
    chq.delete();
    loop_b[3] = 1'b1;
    tick(150);
    loop_b = '0;
    wait_idle();
    `CHK("loop_runs", 1'b1, chq.size() >= 8)
    foreach (chq[i]) `CHK("loop_chan", (i % 2) ? 4'hB : 4'h4, chq[i])
    $display("test loop done");
    // completion set wins over a clear in the same cycle
    clr = 8'hFF;
    tick();
    clr = '0;
    shot[0] = 1'b1;
    tick();
    shot = '0;
    k = 0;
    while (exec_s[0] !== 1'b1 && k < 20) begin tick(); k++; end
    // clear must land on the very edge that sets the flag: sample+1, then sar cycles
    tick(SMP + START_EXTRA + SAR_CYCLES - 1);
    clr[0] = 1'b1;
    tick();
    clr = '0;
    `CHK("first_chan_time", 1'b1, cdone)
    `CHK("set_wins", 1'b1, done_s[0])
    $display("test set_wins done");
    end_of_test();
  end
endmodule : adc_group_scheduler_tb
